// >>> tb_top.sv
// Self-checking bench for the receive and modem status block.
// Assumes an Avalon slave with waitrequest and one-cycle char pulses.
module tb_top
	import urms_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DEPTH = 4;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] addr = 5'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdata;
	logic wait_req;
	logic rx_done = 1'b0;
	logic [7:0] rx_data = 8'h00;
	logic rx_par = 1'b0;
	logic [3:0] level = 4'h0;
	logic slow = 1'b0;
	logic cd_n, ri_n, dsr_n, cts_n, modem_irq, irq;
	int errors = 0;
	int num_checks = 0;

	always #50 clk = ~clk;

	urms_top #(.DEPTH(DEPTH)) uut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_avs_address(addr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
		.i_rx_done(rx_done), .i_rx_data(rx_data), .i_rx_par_bit(rx_par), .i_cd_n(cd_n), .i_ri_n(ri_n),
		.i_dsr_n(dsr_n), .i_cts_n(cts_n), .o_modem_irq(modem_irq), .o_irq(irq));
	urms_peer_model peer (.i_ref_clk(clk), .i_level(level), .i_slow(slow), .o_cd_n(cd_n), .o_ri_n(ri_n),
		.o_dsr_n(dsr_n), .o_cts_n(cts_n));

	// ----------------------------------------
	// Bus and stimulus helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t ns: got %h, expected %h", $time, g, e);
		end
	endtask

	// Waitrequest and read data are both taken at the rising edge that ends the wait
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] d);
		int n;
		@(posedge clk);
		addr <= a;
		wdata <= wd;
		rd <= ~w;
		wr <= w;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wait_req !== 1'b0 && n < 20);
		if (wait_req !== 1'b0) begin
			errors++;
			$display("Error at %0t ns: bus request not answered", $time);
		end
		d = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic rchk(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] d;
		bus(1'b0, a, 32'h0000_0000, d);
		chk(d, e);
	endtask

	task automatic wreg(input logic [4:0] a, input logic [31:0] v);
		logic [31:0] d;
		bus(1'b1, a, v, d);
	endtask

	task automatic rx(input logic [7:0] d, input logic p);
		@(posedge clk);
		rx_done <= 1'b1;
		rx_data <= d;
		rx_par <= p;
		@(posedge clk);
		rx_done <= 1'b0;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		rchk(OFS_LINE_STATE, 32'h0000_0000);
		rchk(OFS_PEER_STATE, 32'h0000_0000);
		rchk(OFS_CTRL, 32'h0000_0000);
		rchk(OFS_IRQ_MASK, 32'h0000_0000);
		rchk(5'h1C, 32'h0000_0000);
	endtask

	task automatic t_single;
		wreg(OFS_CTRL, 32'h0000_0006);
		rx(8'h5A, 1'b1);
		rchk(OFS_LINE_STATE, 32'h0000_0005);
		rchk(OFS_LINE_STATE, 32'h0000_0001);
		rchk(OFS_RX_DATA, 32'h0000_005A);
		rchk(OFS_LINE_STATE, 32'h0000_0000);
		wreg(OFS_CTRL, 32'h0000_0002);
		rx(8'h5A, 1'b1);
		rchk(OFS_LINE_STATE, 32'h0000_0001);
		rchk(OFS_RX_DATA, 32'h0000_005A);
	endtask

	task automatic t_overrun;
		wreg(OFS_CTRL, 32'h0000_0000);
		rx(8'h11, 1'b0);
		rx(8'h22, 1'b0);
		rchk(OFS_LINE_STATE, 32'h0000_0003);
		rchk(OFS_SHIFT_REG, 32'h0000_0022);
		rchk(OFS_RX_DATA, 32'h0000_0011);
		rchk(OFS_LINE_STATE, 32'h0000_0000);
	endtask

	task automatic t_fifo;
		int i;
		logic [7:0] c;
		wreg(OFS_CTRL, 32'h0000_0007);
		rx(8'h5A, 1'b0);
		rx(8'h3C, 1'b1);
		rchk(OFS_LINE_STATE, 32'h0000_0001);
		rchk(OFS_RX_DATA, 32'h0000_005A);
		rchk(OFS_LINE_STATE, 32'h0000_0005);
		rchk(OFS_RX_DATA, 32'h0000_003C);
		for (i = 0; i < DEPTH; i++) begin
			c = 8'h40 + 8'(i);
			rx(c, ^c);
		end
		rx(8'hEE, 1'b0);
		rchk(OFS_LINE_STATE, 32'h0000_0003);
		rchk(OFS_SHIFT_REG, 32'h0000_00EE);
		for (i = 0; i < DEPTH; i++) begin
			rchk(OFS_RX_DATA, {24'h00_0000, 8'h40 + 8'(i)});
		end
		rchk(OFS_LINE_STATE, 32'h0000_0000);
	endtask

	task automatic t_modem;
		int i;
		for (i = 0; i <= 4; i++) begin
			@(posedge clk);
			slow <= i[0];
			level <= level ^ ((i == 4) ? 4'hF : 4'h1 << i);
			repeat (10) @(posedge clk);
			chk({31'h0000_0000, modem_irq}, 32'h0000_0001);
			rchk(OFS_PEER_STATE, {24'h00_0000, level, (i == 4) ? 4'hF : 4'h1 << i});
			chk({31'h0000_0000, modem_irq}, 32'h0000_0000);
			rchk(OFS_PEER_STATE, {24'h00_0000, level, 4'h0});
		end
	endtask

	// Loop levels replace the pins; entering and leaving loopback counts as a change
	task automatic t_loop;
		wreg(OFS_CTRL, 32'h0000_00A8);
		rchk(OFS_CTRL, 32'h0000_00A8);
		@(posedge clk);
		level <= 4'h5;
		repeat (10) @(posedge clk);
		rchk(OFS_PEER_STATE, 32'h0000_00AA);
		wreg(OFS_CTRL, 32'h0000_0000);
		rchk(OFS_PEER_STATE, 32'h0000_005F);
		@(posedge clk);
		level <= 4'h0;
		repeat (10) @(posedge clk);
		rchk(OFS_PEER_STATE, 32'h0000_0005);
		rchk(OFS_PEER_STATE, 32'h0000_0000);
	endtask

	task automatic t_irq;
		wreg(OFS_IRQ_STATUS, 32'h0000_000F);
		wreg(OFS_IRQ_MASK, 32'h0000_0001);
		chk({31'h0000_0000, irq}, 32'h0000_0000);
		rx(8'h5A, 1'b0);
		rchk(OFS_IRQ_STATUS, 32'h0000_0001);
		chk({31'h0000_0000, irq}, 32'h0000_0001);
		wreg(OFS_IRQ_MASK, 32'h0000_0000);
		chk({31'h0000_0000, irq}, 32'h0000_0000);
		wreg(OFS_IRQ_MASK, 32'h0000_0001);
		wreg(OFS_IRQ_STATUS, 32'h0000_0001);
		chk({31'h0000_0000, irq}, 32'h0000_0000);
		rchk(OFS_RX_DATA, 32'h0000_005A);
		wreg(OFS_IRQ_STATUS, 32'h0000_000F);
		wreg(OFS_CTRL, 32'h0000_0006);
		wreg(OFS_IRQ_MASK, 32'h0000_0006);
		rx(8'h5A, 1'b1);
		rx(8'h22, 1'b0);
		rchk(OFS_IRQ_STATUS, 32'h0000_0007);
		chk({31'h0000_0000, irq}, 32'h0000_0001);
		rchk(OFS_LINE_STATE, 32'h0000_0007);
		rchk(OFS_RX_DATA, 32'h0000_005A);
		wreg(OFS_IRQ_STATUS, 32'h0000_0007);
		wreg(OFS_IRQ_MASK, 32'h0000_0008);
		@(posedge clk);
		level <= 4'h2;
		repeat (10) @(posedge clk);
		chk({31'h0000_0000, irq}, 32'h0000_0001);
		rchk(OFS_IRQ_STATUS, 32'h0000_0008);
		rchk(OFS_PEER_STATE, 32'h0000_0022);
	endtask

	task automatic wrap_up;
		$display("Checks: %0d, mismatches: %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		t_reset;
		t_single;
		t_overrun;
		t_fifo;
		t_modem;
		t_loop;
		t_irq;
		wrap_up;
	end

	// Whole run is well under 2000 cycles
	initial begin
		#1_000_000;
		errors++;
		wrap_up;
	end
endmodule

// >>> urms_peer_model.sv
// Modem-side model driving the four active-low status inputs.
// Assumes the bench changes i_level just after a rising edge.
module urms_peer_model (
	input wire logic i_ref_clk,
	input wire logic [3:0] i_level,
	input wire logic i_slow,
	output logic o_cd_n,
	output logic o_ri_n,
	output logic o_dsr_n,
	output logic o_cts_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [11:0] lag_q = 12'h000;
	logic [3:0] lvl;
	// Slow peer: levels reach the pins three cycles late
	always @(posedge i_ref_clk) begin
		lag_q <= {lag_q[7:0], i_level};
	end
	assign lvl = i_slow ? lag_q[11:8] : i_level;
	assign {o_cd_n, o_ri_n, o_dsr_n, o_cts_n} = ~lvl;
endmodule

// >>> urms_pkg.sv
// Package for the UART receive status and modem status block.
// Assumes one clock domain; shared by the top module and its bench.
package urms_pkg;

	// ----------------------------------------
	// Register byte offsets (word aligned)
	// ----------------------------------------
	localparam logic [4:0] OFS_RX_DATA = 5'h00;
	localparam logic [4:0] OFS_LINE_STATE = 5'h04;
	localparam logic [4:0] OFS_PEER_STATE = 5'h08;
	localparam logic [4:0] OFS_CTRL = 5'h0C;
	localparam logic [4:0] OFS_IRQ_STATUS = 5'h10;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h14;
	localparam logic [4:0] OFS_SHIFT_REG = 5'h18;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int LS_AVAIL_BIT = 0;
	localparam int LS_OVERFLOW_BIT = 1;
	localparam int LS_PARITY_BIT = 2;
	localparam int CTRL_FIFO_EN_BIT = 0;
	localparam int CTRL_PAR_EN_BIT = 1;
	localparam int CTRL_PAR_EVEN_BIT = 2;
	localparam int CTRL_LOOP_BIT = 3;
	localparam int CTRL_LOOP_LSB = 4;
	localparam int IRQ_RX_BIT = 0;
	localparam int IRQ_OVERFLOW_BIT = 1;
	localparam int IRQ_PARITY_BIT = 2;
	localparam int IRQ_PEER_BIT = 3;

	// ----------------------------------------
	// Reset values and sizes
	// ----------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
	localparam int RX_FIFO_DEPTH = 16;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

endpackage

// >>> urms_sync.sv
// Two flip-flop synchroniser for a bus of independent levels.
// Assumes an asynchronous active-low reset; also used to release reset.
module urms_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	import urms_pkg::*;

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} urms_sync_st_t;

	urms_sync_st_t st_q;
	urms_sync_st_t st_d;

	always_comb begin
		st_d.s1 = i_d;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q <= {RESET_VAL, RESET_VAL};
		end else begin
			st_q <= st_d;
		end
	end

	assign o_q = st_q.s2;

endmodule

// >>> urms_top.sv
// Receive status flags, receive FIFO and modem status for one UART channel.
// Assumes a receiver on the same clock giving one-cycle char pulses,
// and modem inputs that are asynchronous, active low.
module urms_top
	import urms_pkg::*;
#(
	parameter int DEPTH = urms_pkg::RX_FIFO_DEPTH
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_rx_done,
	input wire logic [7:0] i_rx_data,
	input wire logic i_rx_par_bit,
	input wire logic i_cd_n,
	input wire logic i_ri_n,
	input wire logic i_dsr_n,
	input wire logic i_cts_n,
	output logic o_modem_irq,
	output logic o_irq
);
	import urms_pkg::*;

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(DEPTH);
	localparam logic [AW:0] ONE_CNT = (AW + 1)'(1);

	// ----------------------------------------
	// Reset release and input synchronisers
	// ----------------------------------------
	logic rst_n;
	logic [3:0] peer_n_sync;

	urms_sync #(
		.W(1),
		.RESET_VAL(1'b0)
	) u_rst_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_d(1'b1),
		.o_q(rst_n)
	);

	// Idle modem lines are high, so start synchronisers high
	urms_sync #(
		.W(4),
		.RESET_VAL(4'hF)
	) u_peer_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(rst_n),
		.i_d({i_cd_n, i_ri_n, i_dsr_n, i_cts_n}),
		.o_q(peer_n_sync)
	);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [DEPTH-1:0][8:0] mem;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0] cnt;
		logic [7:0] shift_reg;
		logic overflow;
		logic parity;
		logic head_ack;
		logic [7:0] ctrl;
		logic [3:0] prev;
		logic primed;
		logic [3:0] peer_change_bits;
		logic [3:0] sts;
		logic [3:0] mask;
	} urms_st_t;

	urms_st_t st_q;
	urms_st_t st_d;

	logic fifo_en;
	logic loopback;
	logic [AW:0] cap;
	logic full;
	logic par_bad;
	logic push;
	logic pop;
	logic [3:0] peer_levels;
	logic [3:0] delta;
	logic par_view;
	logic [7:0] line_state_flags;
	logic [7:0] peer_signal_state;
	logic req_new;
	logic rd_line;
	logic rd_peer;
	logic [3:0] ev;

	always_comb begin
		fifo_en = st_q.ctrl[CTRL_FIFO_EN_BIT];
		loopback = st_q.ctrl[CTRL_LOOP_BIT];
		// Without FIFO mode the holding register is a one-deep FIFO
		cap = fifo_en ? DEPTH_CNT : ONE_CNT;
		full = (st_q.cnt >= cap);
		par_bad = st_q.ctrl[CTRL_PAR_EN_BIT] & ((^{i_rx_data, i_rx_par_bit}) ^ ~st_q.ctrl[CTRL_PAR_EVEN_BIT]);
		push = i_rx_done & ~full;
		// Loop bits 7..4 stand in for CD, RI, DSR, CTS
		peer_levels = loopback ? st_q.ctrl[CTRL_LOOP_LSB +: 4] : ~peer_n_sync;
		delta = st_q.primed ? (peer_levels ^ st_q.prev) : 4'h0;
		// FIFO mode reports the head entry, acknowledged once per head
		par_view = fifo_en ? ((st_q.cnt != '0) & st_q.mem[st_q.rd_ptr][8] & ~st_q.head_ack) : st_q.parity;
		line_state_flags = 8'h00;
		line_state_flags[LS_AVAIL_BIT] = (st_q.cnt != '0);
		line_state_flags[LS_OVERFLOW_BIT] = st_q.overflow;
		line_state_flags[LS_PARITY_BIT] = par_view;
		peer_signal_state = {peer_levels, st_q.peer_change_bits};
		// Side effects fire once, on the first cycle of a request
		req_new = (i_avs_read | i_avs_write) & ~st_q.ack;
		rd_line = req_new & i_avs_read & (i_avs_address == OFS_LINE_STATE);
		rd_peer = req_new & i_avs_read & (i_avs_address == OFS_PEER_STATE);
		pop = req_new & i_avs_read & (i_avs_address == OFS_RX_DATA) & (st_q.cnt != '0);
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_d = st_q;
		ev = 4'h0;
		st_d.ack = req_new;
		st_d.primed = 1'b1;
		st_d.prev = peer_levels;

		// Bus read data, captured on the same edge that drops waitrequest
		if (req_new && i_avs_read) begin
			case (i_avs_address)
				OFS_RX_DATA: st_d.rdata = {24'h00_0000, st_q.mem[st_q.rd_ptr][7:0]};
				OFS_LINE_STATE: st_d.rdata = {24'h00_0000, line_state_flags};
				OFS_PEER_STATE: st_d.rdata = {24'h00_0000, peer_signal_state};
				OFS_CTRL: st_d.rdata = {24'h00_0000, st_q.ctrl};
				OFS_IRQ_STATUS: st_d.rdata = {28'h000_0000, st_q.sts};
				OFS_IRQ_MASK: st_d.rdata = {28'h000_0000, st_q.mask};
				OFS_SHIFT_REG: st_d.rdata = {24'h00_0000, st_q.shift_reg};
				default: st_d.rdata = UNMAPPED_READ;
			endcase
		end

		// Software writes
		if (req_new && i_avs_write) begin
			case (i_avs_address)
				OFS_CTRL: st_d.ctrl = i_avs_writedata[7:0];
				OFS_IRQ_MASK: st_d.mask = i_avs_writedata[3:0];
				default: st_d.ctrl = st_q.ctrl;
			endcase
		end

		// Receive path
		if (i_rx_done) begin
			st_d.shift_reg = i_rx_data;
		end
		if (rd_line) begin
			st_d.overflow = 1'b0;
			st_d.parity = 1'b0;
			st_d.head_ack = 1'b1;
		end
		if (pop) begin
			st_d.rd_ptr = st_q.rd_ptr + 1'b1;
			st_d.head_ack = 1'b0;
		end
		if (push) begin
			st_d.mem[st_q.wr_ptr] = {par_bad, i_rx_data};
			st_d.wr_ptr = st_q.wr_ptr + 1'b1;
			st_d.parity = par_bad;
			ev[IRQ_RX_BIT] = 1'b1;
			ev[IRQ_PARITY_BIT] = par_bad;
			// An empty FIFO gets a fresh head; its flag is not yet seen
			if (st_q.cnt == '0) begin
				st_d.head_ack = 1'b0;
			end
		end
		if (i_rx_done && full) begin
			st_d.overflow = 1'b1;
			ev[IRQ_OVERFLOW_BIT] = 1'b1;
		end
		case ({push, pop})
			2'b10: st_d.cnt = st_q.cnt + ONE_CNT;
			2'b01: st_d.cnt = st_q.cnt - ONE_CNT;
			default: st_d.cnt = st_q.cnt;
		endcase

		// Change bits: a change in the reading cycle survives the clear
		st_d.peer_change_bits = (st_q.peer_change_bits & ~{4{rd_peer}}) | delta;
		ev[IRQ_PEER_BIT] = |delta;

		// Interrupt status: write one to clear, a new event wins
		if (req_new && i_avs_write && (i_avs_address == OFS_IRQ_STATUS)) begin
			st_d.sts = st_q.sts & ~i_avs_writedata[3:0];
		end
		st_d.sts = st_d.sts | ev;
	end

	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
			st_q.ctrl <= CTRL_RESET;
			st_q.mask <= IRQ_MASK_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~st_q.ack;
	assign o_avs_readdata = st_q.rdata;
	assign o_modem_irq = |st_q.peer_change_bits;
	assign o_irq = |(st_q.sts & st_q.mask);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_char_in_full;
		i_rx_done && full;
	endsequence

	sequence s_peer_read;
		rd_peer ##1 !o_avs_waitrequest;
	endsequence

	overflow_set_a: assert property (s_char_in_full |=> st_q.overflow)
		else $error("overflow flag not set on full receive");
	overflow_nopush_a: assert property (s_char_in_full and !pop |=> st_q.cnt == $past(st_q.cnt))
		else $error("character pushed into full fifo");
	shift_load_a: assert property (i_rx_done |=> st_q.shift_reg == $past(i_rx_data))
		else $error("shift register not overwritten");
	avail_set_a: assert property (push |=> line_state_flags[LS_AVAIL_BIT])
		else $error("char available flag missing after store");
	avail_zero_a: assert property (pop && st_q.cnt == ONE_CNT && !push |=> !line_state_flags[LS_AVAIL_BIT])
		else $error("char available flag stuck after last pop");
	parity_hold_a: assert property (push && !fifo_en && par_bad |=> st_q.parity [*1] ##1 (st_q.parity || $past(rd_line) || $past(push)))
		else $error("parity flag lost");
	head_parity_a: assert property (fifo_en && $rose(st_q.cnt != '0) |-> par_view == st_q.mem[st_q.rd_ptr][8])
		else $error("parity flag not from fifo head");
	change_set_a: assert property (st_q.primed && peer_levels != st_q.prev |=> (st_q.peer_change_bits & $past(delta)) == $past(delta))
		else $error("change bit not set on input change");
	change_clr_a: assert property (s_peer_read |-> st_q.peer_change_bits == $past(delta))
		else $error("change bits not cleared by read");
	modem_irq_a: assert property ($rose(|st_q.peer_change_bits) |-> o_modem_irq ##0 $past(|delta))
		else $error("modem interrupt not raised with change bit");
	levels_a: assert property (!loopback |-> peer_signal_state[7:4] == ~peer_n_sync)
		else $error("peer levels not inverted inputs");
	line_clear_a: assert property (rd_line && !i_rx_done |=> !st_q.overflow && (fifo_en || !st_q.parity || $past(push)))
		else $error("line state read did not clear flags");

	// ----------------------------------------
	// Bus answers
	// ----------------------------------------
	// Capture and side effects share one edge: data shows the view before the clear
	sequence s_line_read;
		rd_line ##1 !o_avs_waitrequest;
	endsequence

	bus_one_wait_a: assert property (req_new |=> !o_avs_waitrequest)
		else $error("bus request held more than one wait cycle");
	ack_pulse_a: assert property (st_q.ack |=> !st_q.ack)
		else $error("acknowledge stood for two cycles");
	line_data_a: assert property (s_line_read |-> o_avs_readdata == {24'h00_0000, $past(line_state_flags)})
		else $error("line state read data wrong");
	peer_data_a: assert property (s_peer_read |-> o_avs_readdata == {24'h00_0000, $past(peer_signal_state)})
		else $error("peer state read data wrong");

	// ----------------------------------------
	// Receive flags and FIFO
	// ----------------------------------------
	// Pointer steps assume a power-of-two depth
	mem_intact_a: assert property (s_char_in_full |=> st_q.mem == $past(st_q.mem))
		else $error("fifo contents changed on overflow");
	wr_ptr_hold_a: assert property (s_char_in_full |=> st_q.wr_ptr == $past(st_q.wr_ptr))
		else $error("write pointer moved on overflow");
	cnt_bound_a: assert property (st_q.cnt <= DEPTH_CNT)
		else $error("fifo count above depth");
	push_step_a: assert property (push && !pop |=> st_q.cnt == $past(st_q.cnt) + ONE_CNT)
		else $error("fifo count not raised by store");
	pop_step_a: assert property (pop && !push |=> st_q.cnt == $past(st_q.cnt) - ONE_CNT)
		else $error("fifo count not lowered by read");
	head_store_a: assert property (push && st_q.cnt == '0 |=> st_q.mem[st_q.rd_ptr][7:0] == $past(i_rx_data))
		else $error("stored character not at head");
	avail_hold_a: assert property (st_q.cnt != '0 && !pop |=> line_state_flags[LS_AVAIL_BIT])
		else $error("char available flag dropped without read");
	shift_hold_a: assert property (!i_rx_done |=> st_q.shift_reg == $past(st_q.shift_reg))
		else $error("shift register changed without character");
	overflow_hold_a: assert property (st_q.overflow && !rd_line |=> st_q.overflow)
		else $error("overflow flag lost before line state read");
	parity_clear_a: assert property (push && !fifo_en && !par_bad |=> !st_q.parity)
		else $error("parity flag not cleared by good character");
	head_mask_a: assert property (rd_line && fifo_en && !push |=> !par_view)
		else $error("head parity flag not masked after read");

	// ----------------------------------------
	// Interrupt status
	// ----------------------------------------
	sts_set_a: assert property (push |=> st_q.sts[IRQ_RX_BIT])
		else $error("char stored status not set");
	sts_w1c_a: assert property (req_new && i_avs_write && (i_avs_address == OFS_IRQ_STATUS) && ev == 4'h0
		|=> (st_q.sts & $past(i_avs_writedata[3:0])) == 4'h0)
		else $error("interrupt status not cleared by write");

	// ----------------------------------------
	// Modem status
	// ----------------------------------------
	// A change seen in the reading cycle is kept, so only a quiet read clears all bits
	change_hold_a: assert property (!rd_peer |=> (st_q.peer_change_bits & $past(st_q.peer_change_bits)) == $past(st_q.peer_change_bits))
		else $error("change bit lost without read");
	change_quiet_a: assert property (!rd_peer && delta == 4'h0 |=> st_q.peer_change_bits == $past(st_q.peer_change_bits))
		else $error("change bit set without input change");
	modem_irq_clr_a: assert property (rd_peer && delta == 4'h0 |=> !o_modem_irq)
		else $error("modem interrupt stands after quiet read");
	peer_irq_ev_a: assert property (|delta |=> st_q.sts[IRQ_PEER_BIT])
		else $error("modem change status not set");
	loop_levels_a: assert property (loopback |-> peer_signal_state[7:4] == st_q.ctrl[CTRL_LOOP_LSB +: 4])
		else $error("loop levels not shown");

endmodule
